// >>> src/nzap_policy.sv
// Zone access policy engine with APB register access
// Notes on behaviour
// (RL1) Reset while reset pin low or floating
// (RL2) Sixty-four zones, some with counters
// (RL3) Each zone read, written, updated separately
// (RL4) Counter is unsigned 24 bits, optional
// (RL5) Counter only ever decreases
// (RL6) Counter zone may have empty segment
// (RL7) Counterless zone always has a segment
// (RL8) Read access: always, then never
// (RL9) Read condition only tightens, while right held
// (RL10) Update access: always, then never
// (RL11) Update condition only tightens, while right held
// (RL12) Decrement refused at zero, may write data
// (RL13) Overrunning update refused; counter zones excluded
// (RL14) Read checks access, truncates at zone end
// (RL15) Refused request changes nothing, reports refusal
//
// Local design decisions: the APB register port and the address map.
`timescale 1ns/1ps
module nzap_policy (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        reset_pin,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq
);

  // ==========================================================
  // Core reset from the reset pin
  // ==========================================================
  logic core_rst_n;  // Synchronised pin, async reset of the core

  nzap_rst_sync u_rst (
    .clk        (clk),
    .rst_n      (rst_n),
    .reset_pin  (reset_pin),
    .core_rst_n (core_rst_n)
  );

  // ==========================================================
  // State
  // ==========================================================
  typedef enum logic [1:0] {S_IDLE, S_CHECK, S_COPY, S_DONE} nzap_state_t;

  nzap_state_t          state;          // Engine state
  nzap_pkg::nzap_cmd_t  cmd;            // Latched command
  nzap_pkg::nzap_res_t  res;            // Last result
  nzap_pkg::nzap_res_t  next_res;       // Result of the checks
  logic [4:0]           clen;           // Bytes to move
  logic [4:0]           next_clen;      // Truncated length
  logic [3:0]           idx;            // Byte index during copy
  logic [63:0]          rd_never;       // Read access never, per zone
  logic [63:0]          rd_chg;         // Read change right, per zone
  logic [63:0]          up_never;       // Update access never, per zone
  logic [63:0]          up_chg;         // Update change right, per zone
  logic [23:0]          ctr [64];       // Counters
  logic [7:0]           mem [1024];     // Data segments, 16 bytes a zone
  logic [7:0]           dbuf [16];      // Data buffer shared with software
  logic [1:0]           int_stat;       // Sticky events
  logic [1:0]           int_mask;       // Event enables

  // ==========================================================
  // Zone under command
  // ==========================================================
  logic [5:0]               z;          // Zone index
  nzap_pkg::nzap_layout_t   lay;        // Fixed layout of the zone
  logic [23:0]              ctr_z;      // Counter of the zone
  logic [5:0]               end_pos;    // Offset plus length
  logic [4:0]               avail;      // Bytes from offset to end
  logic                     rd_req;     // Read condition change asked
  logic                     up_req;     // Update condition change asked
  logic                     refuse;     // Checks failed
  logic [3:0]               byte_pos;   // Segment byte under copy
  logic [9:0]               maddr;      // Memory address under copy

  // Layout is fixed per zone: counter zones may lack a segment, others not
  assign z        = cmd.zone;                               // [RL2] [RL3]
  assign lay      = nzap_pkg::nzap_layout(z);               // [RL6] [RL7]
  assign ctr_z    = ctr[z];
  assign end_pos  = {1'b0, cmd.off} + {1'b0, cmd.len};
  assign avail    = lay.seg_len - cmd.off;
  assign rd_req   = cmd.rd_never | cmd.rd_lock;
  assign up_req   = cmd.upd_never | cmd.upd_lock;
  assign byte_pos = 4'(cmd.off + 5'(idx));
  assign maddr    = {z, byte_pos};

  // ==========================================================
  // Policy checks
  // ==========================================================
  // First failing check names the refusal
  always_comb
  begin
    next_res  = nzap_pkg::RES_OK;
    next_clen = cmd.len;
    unique case (cmd.op)
      nzap_pkg::OP_READ:
      begin
        if (rd_never[z])                                    // [RL8] [RL14]
          next_res = nzap_pkg::RES_DENIED;
        else if (cmd.off > lay.seg_len)
          next_res = nzap_pkg::RES_BOUNDS;
        else if (cmd.len > avail)                           // [RL14]
          next_clen = avail;
      end
      nzap_pkg::OP_UPDATE:
      begin
        if (lay.has_ctr)                                    // [RL13]
          next_res = nzap_pkg::RES_KIND;
        else if (up_never[z])                               // [RL10]
          next_res = nzap_pkg::RES_DENIED;
        else if (end_pos > {1'b0, lay.seg_len})             // [RL13]
          next_res = nzap_pkg::RES_BOUNDS;
      end
      nzap_pkg::OP_DECR:
      begin
        if (!lay.has_ctr)                                   // [RL4]
          next_res = nzap_pkg::RES_NOCTR;
        else if (ctr_z == 24'h00_0000)                      // [RL12]
          next_res = nzap_pkg::RES_ZERO;
        else if (up_never[z])                               // [RL10]
          next_res = nzap_pkg::RES_DENIED;
        else if (end_pos > {1'b0, lay.seg_len})
          next_res = nzap_pkg::RES_BOUNDS;
      end
      default:
        next_res = nzap_pkg::RES_KIND;
    endcase
    // Read moves only the read condition, update only the update one
    if (next_res == nzap_pkg::RES_OK)
    begin
      if ((rd_req && cmd.op == nzap_pkg::OP_UPDATE) ||
          (up_req && cmd.op == nzap_pkg::OP_READ))
        next_res = nzap_pkg::RES_KIND;
      else if ((rd_req && !rd_chg[z]) || (up_req && !up_chg[z])) // [RL9] [RL11]
        next_res = nzap_pkg::RES_LOCKED;
    end
    if (next_res != nzap_pkg::RES_OK)
      next_clen = 5'h00;
  end

  assign refuse = (next_res != nzap_pkg::RES_OK);           // [RL15]

  // ==========================================================
  // Engine
  // ==========================================================
  logic busy;     // Engine not idle
  logic wr_ok;    // APB write takes effect
  logic cmd_wr;   // Command register written

  assign busy = (state != S_IDLE);

  // Check, then copy bytes one a cycle, then report
  always_ff @(posedge clk or negedge core_rst_n)
  begin
    if (!core_rst_n)
    begin
      state <= S_IDLE;
      cmd   <= '0;
      res   <= nzap_pkg::RES_NONE;
      clen  <= 5'h00;
      idx   <= 4'h0;
    end
    else
    begin
      unique case (state)
        S_IDLE:
        begin
          if (cmd_wr)
          begin
            cmd   <= pwdata;
            state <= S_CHECK;
          end
        end
        S_CHECK:
        begin
          res  <= next_res;                                 // [RL15]
          clen <= next_clen;
          idx  <= 4'h0;
          state <= (next_clen != 5'h00) ? S_COPY : S_DONE;
        end
        S_COPY:
        begin
          idx <= idx + 4'h1;
          if ({1'b0, idx} == clen - 5'h01)
            state <= S_DONE;
        end
        S_DONE:
          state <= S_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Zone attributes
  // ==========================================================
  // Only set never or drop a right; nothing loosens them
  always_ff @(posedge clk or negedge core_rst_n)
  begin
    if (!core_rst_n)
    begin
      rd_never <= '0;
      rd_chg   <= '1;
      up_never <= '0;
      up_chg   <= '1;
    end
    else if (state == S_CHECK && !refuse)
    begin
      if (cmd.rd_never)
        rd_never[z] <= 1'b1;                                // [RL9]
      if (cmd.rd_lock)
        rd_chg[z] <= 1'b0;                                  // [RL9]
      if (cmd.upd_never)
        up_never[z] <= 1'b1;                                // [RL11]
      if (cmd.upd_lock)
        up_chg[z] <= 1'b0;                                  // [RL11]
    end
  end

  // Counters: no path ever adds to them
  always_ff @(posedge clk or negedge core_rst_n)
  begin
    if (!core_rst_n)
    begin
      for (int i = 0; i < nzap_pkg::ZONES; i++)
        ctr[i] <= (i % 2 == 1) ? nzap_pkg::CTR_INIT : 24'h00_0000; // [RL4]
    end
    else if (state == S_CHECK && !refuse && cmd.op == nzap_pkg::OP_DECR)
      ctr[z] <= ctr_z - nzap_pkg::CTR_ONE;                  // [RL5] [RL12]
  end

  // Segment store; no reset, contents undefined until written
  always_ff @(posedge clk)
  begin
    if (state == S_COPY && cmd.op != nzap_pkg::OP_READ)
      mem[maddr] <= dbuf[idx];                              // [RL3] [RL12] [RL13]
  end

  // ==========================================================
  // APB slave
  // ==========================================================
  logic mapped;    // Address decodes to a register
  logic is_data;   // Address in the data window
  logic [31:0] rd_mux; // Read value

  assign is_data = (paddr >= nzap_pkg::A_DATA0) && (paddr <= nzap_pkg::A_DATA3) &&
                   (paddr[1:0] == 2'h0);
  assign mapped  = is_data || paddr == nzap_pkg::A_CMD || paddr == nzap_pkg::A_STATUS ||
                   paddr == nzap_pkg::A_INT_STAT || paddr == nzap_pkg::A_INT_MASK ||
                   paddr == nzap_pkg::A_ZINFO || paddr == nzap_pkg::A_ZCTR;
  // Zero wait states; busy engine refuses command and buffer writes
  assign pready  = 1'b1;
  assign pslverr = psel && penable && (!mapped ||
                   (pwrite && busy && (is_data || paddr == nzap_pkg::A_CMD)));
  assign wr_ok   = psel && penable && pwrite && !pslverr;
  assign cmd_wr  = wr_ok && paddr == nzap_pkg::A_CMD;

  // Read value chosen from the setup-phase address
  always_comb
  begin
    nzap_pkg::nzap_status_t st;
    nzap_pkg::nzap_zinfo_t  zi;
    st         = '0;
    st.busy    = busy;
    st.res     = res;
    st.len     = clen;
    zi         = '0;
    zi.seg_len = lay.seg_len;
    zi.has_ctr = lay.has_ctr;
    zi.rd_never = rd_never[z];
    zi.rd_chg  = rd_chg[z];
    zi.up_never = up_never[z];
    zi.up_chg  = up_chg[z];
    rd_mux     = 32'h0000_0000;
    if (is_data)
      rd_mux = {dbuf[{paddr[3:2], 2'h3}], dbuf[{paddr[3:2], 2'h2}],
                dbuf[{paddr[3:2], 2'h1}], dbuf[{paddr[3:2], 2'h0}]};
    else if (paddr == nzap_pkg::A_CMD)
      rd_mux = cmd;
    else if (paddr == nzap_pkg::A_STATUS)
      rd_mux = st;
    else if (paddr == nzap_pkg::A_INT_STAT)
      rd_mux = {30'h0000_0000, int_stat};
    else if (paddr == nzap_pkg::A_INT_MASK)
      rd_mux = {30'h0000_0000, int_mask};
    else if (paddr == nzap_pkg::A_ZINFO)
      rd_mux = zi;
    else if (paddr == nzap_pkg::A_ZCTR)
      rd_mux = {8'h00, ctr_z};                              // [RL4]
  end

  // Registered read data, captured in the setup cycle
  always_ff @(posedge clk or negedge core_rst_n)
  begin
    if (!core_rst_n)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
      prdata <= rd_mux;
  end

  // Data buffer: software loads it, a read operation fills it
  always_ff @(posedge clk or negedge core_rst_n)
  begin
    if (!core_rst_n)
    begin
      for (int i = 0; i < nzap_pkg::SEG_MAX; i++)
        dbuf[i] <= 8'h00;
    end
    else if (state == S_COPY && cmd.op == nzap_pkg::OP_READ)
      dbuf[idx] <= mem[maddr];                              // [RL14]
    else if (wr_ok && is_data)
    begin
      for (int j = 0; j < 4; j++)
        if (pstrb[j])
          dbuf[{paddr[3:2], 2'(j)}] <= pwdata[8*j +: 8];
    end
  end

  // ==========================================================
  // Interrupts
  // ==========================================================
  logic [1:0] ev;  // Events this cycle

  assign ev[nzap_pkg::INT_DONE]    = (state == S_DONE);
  assign ev[nzap_pkg::INT_REFUSED] = (state == S_DONE) && res != nzap_pkg::RES_OK; // [RL15]

  // Set wins over a simultaneous clear
  always_ff @(posedge clk or negedge core_rst_n)
  begin
    if (!core_rst_n)
    begin
      int_stat <= nzap_pkg::INT_RESET;
      int_mask <= nzap_pkg::INT_RESET;
    end
    else
    begin
      if (wr_ok && paddr == nzap_pkg::A_INT_STAT)
        int_stat <= (int_stat & ~pwdata[1:0]) | ev;
      else
        int_stat <= int_stat | ev;
      if (wr_ok && paddr == nzap_pkg::A_INT_MASK)
        int_mask <= pwdata[1:0];
    end
  end

  assign irq = |(int_stat & int_mask);

  // ==========================================================
  // Assertions
  // ==========================================================
  default clocking cb @(posedge clk); endclocking
  default disable iff (!core_rst_n);

  AST_READ_NEVER: assert property ( // [RL8]
    (state == S_CHECK && cmd.op == nzap_pkg::OP_READ && rd_never[z])
    |=> (res == nzap_pkg::RES_DENIED && state == S_DONE))
    else $error("Read of a never zone not refused");

  AST_UPD_NEVER: assert property ( // [RL10]
    (state == S_CHECK && cmd.op == nzap_pkg::OP_UPDATE && !lay.has_ctr && up_never[z])
    |=> res == nzap_pkg::RES_DENIED)
    else $error("Update of a never zone not refused");

  AST_RD_STRICT: assert property ( // [RL9]
    1'b1 |=> ((rd_never & $past(rd_never)) == $past(rd_never)) &&
             ((rd_chg & ~$past(rd_chg)) == 64'h0000_0000_0000_0000))
    else $error("Read condition loosened");

  AST_UP_STRICT: assert property ( // [RL11]
    1'b1 |=> ((up_never & $past(up_never)) == $past(up_never)) &&
             ((up_chg & ~$past(up_chg)) == 64'h0000_0000_0000_0000))
    else $error("Update condition loosened");

  AST_CTR_DEC: assert property ( // [RL5]
    (state == S_CHECK && !refuse && cmd.op == nzap_pkg::OP_DECR)
    |=> ctr_z == $past(ctr_z) - nzap_pkg::CTR_ONE)
    else $error("Counter not decremented by one");

  AST_CTR_ZERO: assert property ( // [RL12]
    (state == S_CHECK && cmd.op == nzap_pkg::OP_DECR && lay.has_ctr && ctr_z == 24'h00_0000)
    |=> (res == nzap_pkg::RES_ZERO && ctr_z == 24'h00_0000) ##1 int_stat[nzap_pkg::INT_REFUSED])
    else $error("Decrement at zero not refused");

  AST_UPD_BOUND: assert property ( // [RL13]
    (state == S_CHECK && cmd.op == nzap_pkg::OP_UPDATE && !lay.has_ctr && !up_never[z] &&
     end_pos > {1'b0, lay.seg_len}) |=> (res == nzap_pkg::RES_BOUNDS && state == S_DONE))
    else $error("Overrunning update performed");

  AST_REFUSE_KEEP: assert property ( // [RL15]
    (state == S_CHECK && refuse)
    |=> ($stable(rd_never) && $stable(up_never) && $stable(rd_chg) && $stable(up_chg) &&
         ctr_z == $past(ctr_z) && state == S_DONE) ##1 int_stat[nzap_pkg::INT_REFUSED])
    else $error("Refused request changed the zone");

  AST_READ_TRUNC: assert property ( // [RL14]
    (state == S_CHECK && cmd.op == nzap_pkg::OP_READ && !refuse)
    |=> clen == (($past(cmd.len) > $past(avail)) ? $past(avail) : $past(cmd.len)))
    else $error("Read length not truncated at zone end");

  COV_READ:    cover property (state == S_COPY && cmd.op == nzap_pkg::OP_READ);
  COV_DECR:    cover property (state == S_CHECK && cmd.op == nzap_pkg::OP_DECR && !refuse);
  COV_LOCKED:  cover property (state == S_CHECK && next_res == nzap_pkg::RES_LOCKED);
  COV_IRQ:     cover property (irq);

endmodule

// >>> src/nzap_pkg.sv
// Package: constants and types shared by the zone access policy block
package nzap_pkg;

  // ==========================================================
  // Zone geometry
  // ==========================================================
  localparam int          ZONES    = 64;            // Zone count
  localparam int          SEG_MAX  = 16;            // Bytes per data segment
  localparam logic [4:0]  SEG_FULL = 5'h10;         // Length of a full segment
  localparam logic [4:0]  SEG_NONE = 5'h00;         // Absent segment
  localparam logic [23:0] CTR_INIT = 24'h00_0100;   // Counter value at reset
  localparam logic [23:0] CTR_ONE  = 24'h00_0001;   // Decrement step

  // ==========================================================
  // Register byte addresses
  // ==========================================================
  localparam logic [7:0] A_CMD      = 8'h00;        // Command, starts an operation
  localparam logic [7:0] A_STATUS   = 8'h04;        // Busy, result, length
  localparam logic [7:0] A_INT_STAT = 8'h08;        // Sticky events, write one to clear
  localparam logic [7:0] A_INT_MASK = 8'h0C;        // Interrupt enables
  localparam logic [7:0] A_ZINFO    = 8'h10;        // Attributes of the command zone
  localparam logic [7:0] A_ZCTR     = 8'h14;        // Counter of the command zone
  localparam logic [7:0] A_DATA0    = 8'h20;        // First of four data words
  localparam logic [7:0] A_DATA3    = 8'h2C;        // Last data word

  // ==========================================================
  // Interrupt bit positions and reset values
  // ==========================================================
  localparam int         INT_DONE    = 0;           // Operation finished
  localparam int         INT_REFUSED = 1;           // Operation refused
  localparam logic [1:0] INT_RESET   = 2'h0;        // Status and mask at reset

  // ==========================================================
  // Types
  // ==========================================================
  typedef enum logic [1:0] {OP_NOP, OP_READ, OP_UPDATE, OP_DECR} nzap_op_t;

  typedef enum logic [2:0] {
    RES_NONE, RES_OK, RES_DENIED, RES_BOUNDS, RES_NOCTR, RES_ZERO, RES_LOCKED, RES_KIND
  } nzap_res_t;

  // Command word layout
  typedef struct packed {
    logic [1:0] rsv_hi;      // Reads back as written
    logic       upd_lock;    // Drop the update change right
    logic       upd_never;   // Make update access never
    logic       rd_lock;     // Drop the read change right
    logic       rd_never;    // Make read access never
    logic [4:0] len;         // Byte count
    logic [4:0] off;         // Byte offset in segment
    logic [1:0] rsv_mid;     // Reads back as written
    logic [5:0] zone;        // Zone index
    logic [5:0] rsv_lo;      // Reads back as written
    nzap_op_t   op;          // Operation
  } nzap_cmd_t;

  // Status word layout
  typedef struct packed {
    logic [18:0] rsv_hi;
    logic [4:0]  len;        // Bytes moved by the last operation
    logic        rsv_mid;
    nzap_res_t   res;        // Result of the last operation
    logic [2:0]  rsv_lo;
    logic        busy;       // Operation in progress
  } nzap_status_t;

  // Zone attribute word layout
  typedef struct packed {
    logic [18:0] rsv_hi;
    logic        up_chg;     // Update change right
    logic        up_never;   // Update access never
    logic        rd_chg;     // Read change right
    logic        rd_never;   // Read access never
    logic        has_ctr;    // Zone carries a counter
    logic [2:0]  rsv_lo;
    logic [4:0]  seg_len;    // Segment length
  } nzap_zinfo_t;

  // Fixed zone layout
  typedef struct packed {
    logic       has_ctr;
    logic [4:0] seg_len;
  } nzap_layout_t;

  // Odd zones carry a counter; zones with index 1 mod 4 have no segment
  function automatic nzap_layout_t nzap_layout(logic [5:0] z);
    nzap_layout_t l;
    l.has_ctr = z[0];
    l.seg_len = (z[1:0] == 2'h1) ? SEG_NONE : SEG_FULL;
    return l;
  endfunction

endpackage

// >>> src/nzap_rst_sync.sv
// Reset pin synchroniser for the zone access policy block
`timescale 1ns/1ps
module nzap_rst_sync (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic reset_pin,
  output logic      core_rst_n
);

  // ==========================================================
  // Two-stage synchroniser
  // ==========================================================
  logic pin_meta;  // First stage, read only by second stage

  // Pin low or floating (pulled down) keeps the core in reset
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_meta   <= 1'b0;
      core_rst_n <= 1'b0;
    end
    else
    begin
      pin_meta   <= reset_pin;   // [RL1]
      core_rst_n <= pin_meta;    // [RL1]
    end
  end

  // Core held in reset two cycles after the pin is seen low
  AST_PIN_RESET: assert property (@(posedge clk) disable iff (!rst_n) // [RL1]
    (!reset_pin) [*2] |=> !core_rst_n)
    else $error("Core left reset while pin low");

endmodule

// >>> verification/nzap_host.sv
// Host model: APB master that issues zone commands
`timescale 1ns/1ps
module nzap_host (
  input  wire logic        clk,
  input  wire logic        pready,
  input  wire logic        pslverr,
  input  wire logic [31:0] prdata,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  output logic [3:0]       pstrb
);
  // ==========================================================
  // Idle bus from time zero
  // ==========================================================
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    pstrb = 4'hF;
  end

  // One transfer, held until pready seen high at an edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

// >>> verification/tb.sv
// Testbench: zone policy scenarios driven through the host model
`timescale 1ns/1ps
module tb;
  // ==========================================================
  // Signals and counters
  // ==========================================================
  logic        clk, rst_n, reset_pin, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic [3:0]  pstrb;
  logic        e;
  int          err_total, total_checks;

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  nzap_policy u_dut (.clk(clk), .rst_n(rst_n), .reset_pin(reset_pin), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
  nzap_host u_host (.clk(clk), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb));

  // ==========================================================
  // Helpers
  // ==========================================================
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    total_checks++;
    if (g !== x)
    begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, g, x);
    end
  endtask
  task automatic rd(input logic [7:0] a);
    u_host.xfer(1'b0, a, 32'h0000_0000, q, e);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_host.xfer(1'b1, a, d, q, e);
  endtask
  // Command word: flags, len, off, zone, op
  function automatic logic [31:0] cw(logic [1:0] op, logic [5:0] z, logic [4:0] o,
                                     logic [4:0] l, logic [3:0] f);
    return {2'b00, f, l, o, 2'b00, z, 6'h00, op};
  endfunction
  // Poll busy under a bound, then judge the result code
  task automatic run(input logic [31:0] c, input logic [2:0] r);
    int n;
    wr(nzap_pkg::A_CMD, c);
    n = 0;
    rd(nzap_pkg::A_STATUS);
    while (q[0] !== 1'b0 && n < 100)
    begin
      rd(nzap_pkg::A_STATUS);
      n++;
    end
    chk({31'h0, q[0]}, 32'h0);
    chk({29'h0, q[6:4]}, {29'h0, r});
  endtask

  // ==========================================================
  // Scenarios
  // ==========================================================
  task automatic t_layout;
    rd(8'h40);
    chk({31'h0, e}, 32'h1);
    run(cw(2'd0, 6'd2, 5'd0, 5'd0, 4'h0), nzap_pkg::RES_KIND);
    rd(nzap_pkg::A_ZINFO);
    chk(q, 32'h0000_1410);
    run(cw(2'd0, 6'd1, 5'd0, 5'd0, 4'h0), nzap_pkg::RES_KIND);
    rd(nzap_pkg::A_ZINFO);
    chk(q, 32'h0000_1500);
    rd(nzap_pkg::A_ZCTR);
    chk(q, 32'h0000_0100);
    $display("layout done");
  endtask

  task automatic t_data;
    for (int k = 0; k < 4; k++)
      wr(8'(nzap_pkg::A_DATA0 + 4 * k), 32'h0302_0100 + 32'h0404_0404 * k);
    run(cw(2'd2, 6'd2, 5'd0, 5'd16, 4'h0), nzap_pkg::RES_OK);
    run(cw(2'd1, 6'd2, 5'd4, 5'd16, 4'h0), nzap_pkg::RES_OK);
    chk({27'h0, q[12:8]}, 32'd12);
    rd(nzap_pkg::A_DATA0);
    chk(q, 32'h0706_0504);
    run(cw(2'd2, 6'd2, 5'd8, 5'd16, 4'h0), nzap_pkg::RES_BOUNDS);
    run(cw(2'd2, 6'd3, 5'd0, 5'd1, 4'h0), nzap_pkg::RES_KIND);
    run(cw(2'd1, 6'd2, 5'd8, 5'd4, 4'h0), nzap_pkg::RES_OK);
    rd(nzap_pkg::A_DATA0);
    chk(q, 32'h0B0A_0908);
    $display("data done");
  endtask

  task automatic t_count;
    run(cw(2'd3, 6'd3, 5'd0, 5'd0, 4'h0), nzap_pkg::RES_OK);
    rd(nzap_pkg::A_ZCTR);
    chk(q, 32'h0000_00FF);
    run(cw(2'd3, 6'd2, 5'd0, 5'd0, 4'h0), nzap_pkg::RES_NOCTR);
    for (int i = 0; i < 256; i++)
      run(cw(2'd3, 6'd1, 5'd0, 5'd0, 4'h0), nzap_pkg::RES_OK);
    run(cw(2'd3, 6'd1, 5'd0, 5'd0, 4'h0), nzap_pkg::RES_ZERO);
    rd(nzap_pkg::A_ZCTR);
    chk(q, 32'h0000_0000);
    $display("count done");
  endtask

  task automatic t_cond;
    run(cw(2'd1, 6'd6, 5'd0, 5'd1, 4'h1), nzap_pkg::RES_OK);
    rd(nzap_pkg::A_ZINFO);
    chk(q, 32'h0000_1610);
    run(cw(2'd1, 6'd6, 5'd0, 5'd1, 4'h0), nzap_pkg::RES_DENIED);
    run(cw(2'd1, 6'd10, 5'd0, 5'd1, 4'h2), nzap_pkg::RES_OK);
    run(cw(2'd1, 6'd10, 5'd0, 5'd1, 4'h1), nzap_pkg::RES_LOCKED);
    rd(nzap_pkg::A_ZINFO);
    chk(q, 32'h0000_1010);
    run(cw(2'd2, 6'd14, 5'd0, 5'd1, 4'h4), nzap_pkg::RES_OK);
    run(cw(2'd2, 6'd14, 5'd0, 5'd1, 4'h0), nzap_pkg::RES_DENIED);
    run(cw(2'd2, 6'd18, 5'd0, 5'd1, 4'h8), nzap_pkg::RES_OK);
    run(cw(2'd2, 6'd18, 5'd0, 5'd1, 4'h4), nzap_pkg::RES_LOCKED);
    run(cw(2'd1, 6'd18, 5'd0, 5'd1, 4'h4), nzap_pkg::RES_KIND);
    rd(nzap_pkg::A_ZINFO);
    chk(q, 32'h0000_0410);
    $display("cond done");
  endtask

  task automatic t_irq;
    wr(nzap_pkg::A_INT_STAT, 32'h0000_0003);
    wr(nzap_pkg::A_INT_MASK, 32'h0000_0001);
    wr(nzap_pkg::A_CMD, cw(2'd1, 6'd2, 5'd0, 5'd16, 4'h0));
    wr(nzap_pkg::A_CMD, cw(2'd0, 6'd2, 5'd0, 5'd0, 4'h0));
    chk({31'h0, e}, 32'h1);
    repeat (20) @(posedge clk);
    run(cw(2'd0, 6'd2, 5'd0, 5'd0, 4'h0), nzap_pkg::RES_KIND);
    chk({31'h0, irq}, 32'h1);
    rd(nzap_pkg::A_INT_STAT);
    chk(q, 32'h0000_0003);
    wr(nzap_pkg::A_INT_STAT, 32'h0000_0001);
    @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    wr(nzap_pkg::A_INT_MASK, 32'h0000_0002);
    @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    $display("irq done");
  endtask

  // Pin reset clears irq and restores the zone 3 counter
  task automatic t_pin;
    reset_pin <= 1'b0;
    repeat (4) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    reset_pin <= 1'b1;
    repeat (4) @(posedge clk);
    run(cw(2'd0, 6'd3, 5'd0, 5'd0, 4'h0), nzap_pkg::RES_KIND);
    rd(nzap_pkg::A_ZCTR);
    chk(q, 32'h0000_0100);
    $display("pin done");
  endtask

  // ==========================================================
  // Verdict, sequence and watchdog
  // ==========================================================
  task automatic finish_test;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    rst_n = 1'b0;
    reset_pin = 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    reset_pin <= 1'b1;
    repeat (4) @(posedge clk);
    t_layout();
    t_data();
    t_count();
    t_cond();
    t_irq();
    t_pin();
    finish_test();
  end

  // Hang guard, well above the expected run length
  initial
  begin
    repeat (20000) @(posedge clk);
    err_total++;
    finish_test();
  end
endmodule
